// File: rtl/vram_ctrl.sv
// host-side controller for a 64k x 5 dual-port video dram module
// assumes the module's pins wire straight to these ports, and that the
// user waits for cmd_ready before each command; sys_clk at 50 MHz
`timescale 1ns/10ps
`default_nettype none
module vram_ctrl
    import vram_ctrl_pkg::*;
(
    input  wire logic                                sys_clk,
    input  wire logic                                rst,
    // user command port
    input  wire logic                                cmd_valid,
    output logic                                     cmd_ready,
    input  wire vram_ctrl_pkg::op_type               cmd_op,
    input  wire logic [15:0]                         cmd_addr,
    input  wire logic [4:0]                          cmd_slice_mask,
    input  wire logic                                wr_valid,
    output logic                                     wr_ready,
    input  wire logic [4:0]                          wr_data,
    output logic                                     rd_valid,
    output logic [4:0]                               rd_data,
    output logic                                     refresh_busy,
    // device pins
    output logic [7:0]                               multiplexed_address,
    output logic                                     row_strobe_n,
    output logic [4:0]                               column_strobe_n,
    output logic                                     write_select_n,
    output logic                                     transfer_select_output_enable_n,
    input  wire logic [4:0]                          random_data_io_in,
    output logic [4:0]                               random_data_io_out,
    output logic                                     random_data_io_oe,
    output logic                                     serial_output_enable_n
);
    import vram_ctrl_pkg::*;

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    typedef struct packed {
        phase_type   phase;
        op_type      op;
        logic        is_refresh;
        logic [15:0] addr;
        logic [4:0]  slices;
        logic [7:0]  cnt;
        logic [7:0]  ref_row;
        logic [17:0] ref_timer;
        logic        ref_due;
        logic [7:0]  a;
        logic        ras_n;
        logic [4:0]  cas_n;
        logic        we_n;
        logic        trqe_n;
        logic [4:0]  dq_out;
        logic        dq_oe;
        logic        rd_valid;
        logic [4:0]  rd_data;
        logic        cmd_ready;
    } ctrl_state_type;

    ctrl_state_type s_r;
    ctrl_state_type s_nxt;
    vram_fifo_if    wf();
    logic           start;
    logic           is_write;

    vram_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wfifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .f       (wf.fifo)
    );

    assign wf.in_data  = wr_data;
    assign wf.in_valid = wr_valid;
    assign wr_ready    = wf.in_ready;
    // a write waits until its data is in the fifo, so the strobes never stall
    assign is_write    = (cmd_op == OP_WRITE);
    assign start       = cmd_valid && s_r.cmd_ready && !s_r.ref_due && (!is_write || wf.out_valid);
    assign wf.out_ready = (s_r.phase == ST_ROW_HOLD) && (s_r.cnt == CNT_ONE)
                          && (s_r.op == OP_WRITE) && !s_r.is_refresh;

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        case (s_r.phase)
            ST_IDLE:
            begin
                s_nxt.ras_n = 1'b1;
                s_nxt.cas_n = 5'h1f;
                s_nxt.dq_oe = 1'b0;
                if (s_r.ref_due)
                begin
                    // ras-only refresh of the next row, column strobes idle
                    s_nxt.is_refresh = 1'b1;
                    s_nxt.ref_due = 1'b0;
                    s_nxt.op = OP_READ;
                    s_nxt.a = s_r.ref_row;
                    s_nxt.ref_row = s_r.ref_row + 8'h01;
                    s_nxt.we_n = 1'b1;
                    s_nxt.trqe_n = 1'b1;
                    s_nxt.cmd_ready = 1'b0;
                    s_nxt.cnt = 8'(ROW_SETUP_CYC);
                    s_nxt.phase = ST_ROW;
                end
                else if (start)
                begin
                    s_nxt.is_refresh = 1'b0;
                    s_nxt.op = cmd_op;
                    s_nxt.addr = cmd_addr;
                    s_nxt.slices = cmd_slice_mask;
                    s_nxt.a = cmd_addr[15:8];
                    // transfer cycles take the enable pin low before row fall
                    s_nxt.trqe_n = !(cmd_op == OP_LOAD_REG || cmd_op == OP_STORE_REG);
                    // direction: low stores registers into the row
                    s_nxt.we_n = !(cmd_op == OP_STORE_REG);
                    s_nxt.cmd_ready = 1'b0;
                    s_nxt.cnt = 8'(ROW_SETUP_CYC);
                    s_nxt.phase = ST_ROW;
                end
            end
            ST_ROW:
            begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == CNT_ONE)
                begin
                    s_nxt.ras_n = 1'b0;
                    s_nxt.cnt = 8'(ROW_HOLD_CYC);
                    s_nxt.phase = s_r.is_refresh ? ST_COL : ST_ROW_HOLD;
                end
            end
            ST_ROW_HOLD:
            begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == CNT_ONE)
                begin
                    s_nxt.a = s_r.addr[7:0];
                    if (s_r.op == OP_WRITE)
                    begin
                        // early write: select and data settle before column fall
                        s_nxt.we_n = 1'b0;
                        s_nxt.dq_out = wf.out_data;
                        s_nxt.dq_oe = 1'b1;
                    end
                    else if (s_r.op == OP_READ)
                    begin
                        s_nxt.we_n = 1'b1;
                        s_nxt.trqe_n = 1'b1;
                    end
                    s_nxt.cnt = 8'(COL_HOLD_CYC);
                    s_nxt.phase = ST_COL;
                end
            end
            ST_COL:
            begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                // strobe only after the column bits have stood a cycle
                if (s_r.cnt == 8'(COL_HOLD_CYC) && !s_r.is_refresh)
                    s_nxt.cas_n = ~s_r.slices;
                if (s_r.op == OP_READ && !s_r.is_refresh && s_r.cnt == 8'h02)
                    s_nxt.trqe_n = 1'b0;
                if (s_r.cnt == CNT_ONE)
                begin
                    if (s_r.op == OP_READ && !s_r.is_refresh)
                    begin
                        // data out is unlatched: sample before strobes rise
                        s_nxt.rd_valid = 1'b1;
                        s_nxt.rd_data = random_data_io_in;
                    end
                    s_nxt.ras_n = 1'b1;
                    s_nxt.cas_n = 5'h1f;
                    s_nxt.trqe_n = 1'b1;
                    s_nxt.we_n = 1'b1;
                    s_nxt.dq_oe = 1'b0;
                    s_nxt.cnt = 8'(PRECHARGE_CYC);
                    s_nxt.phase = ST_PRECHARGE;
                end
            end
            ST_PRECHARGE:
            begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == CNT_ONE)
                begin
                    s_nxt.is_refresh = 1'b0;
                    s_nxt.cmd_ready = 1'b1;
                    s_nxt.phase = ST_IDLE;
                end
            end
            default:
                s_nxt.phase = ST_IDLE;
        endcase
        // tick after the idle clear, so a new tick is never lost to a take
        s_nxt.ref_timer = s_r.ref_timer + 18'h00001;
        if (s_r.ref_timer == 18'(REFRESH_GAP_CYC - 1))
        begin
            s_nxt.ref_timer = '0;
            s_nxt.ref_due = 1'b1;
        end
        // a pending refresh holds off new commands
        if (s_nxt.ref_due)
            s_nxt.cmd_ready = 1'b0;
        else if (s_nxt.phase == ST_IDLE)
            s_nxt.cmd_ready = 1'b1;
    end

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.phase <= ST_IDLE;
            s_r.ras_n <= 1'b1;
            s_r.cas_n <= 5'h1f;
            s_r.we_n <= 1'b1;
            s_r.trqe_n <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign cmd_ready                       = s_r.cmd_ready;
    assign rd_valid                        = s_r.rd_valid;
    assign rd_data                         = s_r.rd_data;
    assign refresh_busy                    = s_r.is_refresh;
    assign multiplexed_address             = s_r.a;
    assign row_strobe_n                    = s_r.ras_n;
    assign column_strobe_n                 = s_r.cas_n;
    assign write_select_n                  = s_r.we_n;
    assign transfer_select_output_enable_n = s_r.trqe_n;
    assign random_data_io_out              = s_r.dq_out;
    assign random_data_io_oe               = s_r.dq_oe;
    // serial outputs kept enabled; a bank multiplexer would steer this
    assign serial_output_enable_n          = 1'b0;
endmodule : vram_ctrl
`default_nettype wire

// File: rtl/vram_ctrl_pkg.sv
// constants for the controller that drives a 64k x 5 dual-port video dram
// assumes sys_clk at 50 MHz; all device timing is rounded to whole cycles
package vram_ctrl_pkg;
    localparam int  CLK_PERIOD_NS   = 20;
    localparam int  ADDR_W          = 8;
    localparam int  DATA_W          = 5;
    localparam int  ROWS            = 256;
    localparam int  FIFO_DEPTH      = 16;
    // strobe phase lengths, least times rounded up
    localparam int  T_ROW_SETUP_NS  = 40;
    localparam int  T_ROW_HOLD_NS   = 40;
    localparam int  T_COL_HOLD_NS   = 100;
    localparam int  T_PRECHARGE_NS  = 100;
    localparam int  ROW_SETUP_CYC   = (T_ROW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  ROW_HOLD_CYC    = (T_ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  COL_HOLD_CYC    = (T_COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  PRECHARGE_CYC   = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // refresh: 256 rows every 4 ms, longest spacing rounded down
    localparam int  REFRESH_MS      = 4;
    localparam int  REFRESH_GAP_CYC = (REFRESH_MS * 1000000 / CLK_PERIOD_NS) / ROWS;
    localparam logic [7:0] CNT_ONE  = 8'h01;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_LOAD_REG,
        OP_STORE_REG
    } op_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW,
        ST_ROW_HOLD,
        ST_COL,
        ST_PRECHARGE
    } phase_type;
endpackage : vram_ctrl_pkg

// File: rtl/vram_fifo.sv
// small synchronous fifo of flip-flops for write data
// assumes single clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module vram_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    vram_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
        logic          full;
    } fifo_state_type;

    fifo_state_type    s_r;
    fifo_state_type    s_nxt;
    logic [WIDTH-1:0]  mem_r [DEPTH];
    logic              push;
    logic              pop;

    // full kept as its own flop so ready leaves the block straight from a register
    assign f.in_ready  = !s_r.full;
    assign f.out_valid = (s_r.count != '0);
    assign f.out_data  = mem_r[s_r.rd_ptr];
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
            s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
        if (pop)
            s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
        s_nxt.count = s_r.count + (AW+1)'(push) - (AW+1)'(pop);
        s_nxt.full = (s_nxt.count == (AW+1)'(DEPTH));
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
        if (push)
            mem_r[s_r.wr_ptr] <= f.in_data;
    end
endmodule : vram_fifo
`default_nettype wire

// File: rtl/vram_fifo_if.sv
// carrier between the controller and its write-data fifo
// assumes one clock domain; valid/ready handshake on both sides
`timescale 1ns/10ps
`default_nettype none
interface vram_fifo_if;
    logic [4:0] in_data;
    logic       in_valid;
    logic       in_ready;
    logic [4:0] out_data;
    logic       out_valid;
    logic       out_ready;
    modport fifo (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
    modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface : vram_fifo_if
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench: controller, its fifo and a device model on the pins
// assumes the package, interface and fifo are compiled before this file
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import vram_ctrl_pkg::*;
    logic       sys_clk, rst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, refresh_busy;
    logic       row_strobe_n, write_select_n, transfer_select_output_enable_n, io_oe, soe_n, sclk;
    op_type     cmd_op;
    logic [15:0] cmd_addr;
    logic [7:0] multiplexed_address;
    logic [4:0] cmd_slice_mask, wr_data, rd_data, column_strobe_n, io_in, io_out, dev_q, rd_got, sout;
    int         err_total = 0, checks_done = 0, cyc = 0;
    vram_ctrl vram_ctrl_i (.sys_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_slice_mask,
        .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .refresh_busy, .multiplexed_address,
        .row_strobe_n, .column_strobe_n, .write_select_n, .transfer_select_output_enable_n,
        .random_data_io_in(io_in), .random_data_io_out(io_out), .random_data_io_oe(io_oe),
        .serial_output_enable_n(soe_n));
    vram_dev_model vram_dev_model_i (.multiplexed_address, .row_strobe_n, .column_strobe_n,
        .write_select_n, .transfer_select_output_enable_n, .random_data_io_out(io_out), .dev_q,
        .sclk, .serial_output_enable_n(soe_n), .serial_data_output(sout));
    assign io_in = io_oe ? io_out : dev_q;
    // -------------
    // shared tasks
    // -------------
    task automatic test_done();
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic cmd(op_type op, logic [15:0] a, logic [4:0] m);
        int n;
        n = 0;
        rd_got = 'x;
        cmd_op = op;
        {cmd_addr, cmd_slice_mask, cmd_valid} = {a, m, 1'b1};
        while (cmd_ready !== 1'b1 && n < 2000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1 n++;
            if (rd_valid === 1'b1)
                rd_got = rd_data;
        end while (cmd_ready !== 1'b1 && n < 100);
    endtask : cmd
    task automatic push(logic [4:0] d);
        {wr_data, wr_valid} = {d, 1'b1};
        @(posedge sys_clk);
        #1 wr_valid = 1'b0;
    endtask : push
    task automatic shift(int n);
        repeat (n)
        begin
            sclk = 1'b1;
            @(posedge sys_clk);
            #1 sclk = 1'b0;
            @(posedge sys_clk);
            #1;
        end
    endtask : shift
    // ---------
    // scenarios
    // ---------
    task automatic t_fill_drain();
        int acc;
        acc = 0;
        for (int i = 0; i < 20; i++)
        begin
            {wr_data, wr_valid} = {i[4:0], 1'b1};
            if (wr_ready === 1'b1)
                acc++;
            @(posedge sys_clk);
            #1;
        end
        wr_valid = 1'b0;
        `CHK(acc, 16)
        `CHK(wr_ready, 1'b0)
        for (int i = 0; i < 16; i++)
            cmd(OP_WRITE, {8'h12, 3'h0, i[4:0]}, 5'h1f);
        `CHK(wr_ready, 1'b1)
        for (int i = 0; i < 16; i++)
        begin
            cmd(OP_READ, {8'h12, 3'h0, i[4:0]}, 5'h1f);
            `CHK(rd_got, i[4:0])
        end
    endtask : t_fill_drain
    task automatic t_slices();
        push(5'h1f);
        cmd(OP_WRITE, 16'hffff, 5'h1f);
        push(5'h00);
        cmd(OP_WRITE, 16'hffff, 5'h05);
        cmd(OP_READ, 16'hffff, 5'h1f);
        `CHK(rd_got, 5'h1a)
        cmd(OP_LOAD_REG, 16'hff00, 5'h1f);
        shift(255);
        `CHK(sout, 5'h1a)
        cmd(OP_LOAD_REG, 16'hffc0, 5'h1f);
        shift(63);
        `CHK(sout, 5'h1a)
    endtask : t_slices
    task automatic t_transfer();
        for (int c = 0; c < 4; c++)
        begin
            cmd(OP_LOAD_REG, {8'h40 + c[7:0], c[1:0], 6'h00}, 5'h1f);
            `CHK(vram_dev_model_i.seg_r, c[1:0])
            `CHK(vram_dev_model_i.xdir_r, 1'b1)
            `CHK(vram_dev_model_i.xrow_r, 8'h40 + c[7:0])
        end
        cmd(OP_STORE_REG, 16'h7700, 5'h00);
        `CHK(vram_dev_model_i.xdir_r, 1'b0)
        `CHK(vram_dev_model_i.seg_r, 2'h3)
    endtask : t_transfer
    task automatic t_refresh();
        int n, n0;
        logic [7:0] r0;
        n0 = vram_dev_model_i.refresh_cnt;
        for (int k = 1; k < 3; k++)
        begin
            r0 = vram_dev_model_i.rr_r;
            n = 0;
            while (vram_dev_model_i.refresh_cnt < n0 + k && n < 900)
            begin
                @(posedge sys_clk);
                #1 n++;
            end
        end
        `CHK(vram_dev_model_i.refresh_cnt, n0 + 2)
        `CHK(vram_dev_model_i.rr_r, r0 + 8'h01)
    endtask : t_refresh
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        {rst, cmd_valid, wr_valid, sclk} = 4'b1000;
        cmd_op = OP_READ;
        {cmd_addr, cmd_slice_mask, wr_data} = 26'h0000000;
        repeat (16) @(posedge sys_clk);
        #1 rst = 1'b0;
        t_fill_drain();
        t_slices();
        t_transfer();
        t_refresh();
        test_done();
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_total++;
            test_done();
        end
    end
endmodule : testbench
`default_nettype wire

// File: tb/vram_ctrl_props.sv
// pin-level checker for the video dram controller
// assumes a bind onto vram_ctrl; one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module vram_ctrl_props (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       cmd_ready,
    input wire logic       rd_valid,
    input wire logic       refresh_busy,
    input wire logic [7:0] multiplexed_address,
    input wire logic       row_strobe_n,
    input wire logic [4:0] column_strobe_n,
    input wire logic       write_select_n,
    input wire logic       transfer_select_output_enable_n,
    input wire logic       random_data_io_oe,
    input wire logic       serial_output_enable_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [10:0] gap_r;
    logic        cas_fall;
    // cycles since the row strobe was last low; a read may delay refresh
    always_ff @(posedge sys_clk)
        gap_r <= (rst || !row_strobe_n) ? 11'h000 : gap_r + 11'h001;
    assign cas_fall = |(~column_strobe_n & ~{5{rst}});
    a_row_addr_hold: assert property ($fell(row_strobe_n) |-> $stable(multiplexed_address)) else $error("row addr moved");
    a_col_addr_hold: assert property (|($past(column_strobe_n) & ~column_strobe_n) |-> $stable(multiplexed_address)) else $error("col addr moved");
    a_early_write: assert property (|($past(column_strobe_n) & ~column_strobe_n) && !write_select_n |-> $past(!write_select_n)) else $error("late write");
    a_drive_write: assert property (random_data_io_oe |-> !write_select_n) else $error("data driven outside write");
    a_read_gated: assert property (rd_valid |-> $past(!transfer_select_output_enable_n && write_select_n)) else $error("read not enabled");
    a_refresh_quiet: assert property (refresh_busy |-> &column_strobe_n && !random_data_io_oe) else $error("refresh not row only");
    a_refresh_kind: assert property ($fell(row_strobe_n) && refresh_busy |-> transfer_select_output_enable_n) else $error("refresh as transfer");
    a_refresh_gap: assert property (gap_r <= 11'h334) else $error("row strobe gap too long");
    a_serial_on: assert property (!serial_output_enable_n) else $error("serial outputs disabled");
    a_rd_pulse: assert property (rd_valid |=> !rd_valid) else $error("read valid too long");
    a_reset_idle: assert property ($fell(rst) |-> row_strobe_n && &column_strobe_n && !random_data_io_oe && !cmd_ready) else $error("not idle after reset");
    c_cas: cover property (cas_fall);
endmodule : vram_ctrl_props
bind vram_ctrl vram_ctrl_props vram_ctrl_props_i (.sys_clk, .rst, .cmd_ready, .rd_valid, .refresh_busy,
    .multiplexed_address, .row_strobe_n, .column_strobe_n, .write_select_n, .transfer_select_output_enable_n,
    .random_data_io_oe, .serial_output_enable_n);
`default_nettype wire

// File: tb/vram_dev_model.sv
// behavioural 64k x 5 dual-port dram seen at the controller's pins
// assumes the bench resolves the shared data lines; serial input not modelled
`timescale 1ns/10ps
`default_nettype none
module vram_dev_model (
    input  wire logic [7:0] multiplexed_address,
    input  wire logic       row_strobe_n,
    input  wire logic [4:0] column_strobe_n,
    input  wire logic       write_select_n,
    input  wire logic       transfer_select_output_enable_n,
    input  wire logic [4:0] random_data_io_out,
    input  wire logic       sclk,
    input  wire logic       serial_output_enable_n,
    output logic      [4:0] dev_q,
    output logic      [4:0] serial_data_output
);
    logic [4:0] mem [65536];
    logic [7:0] row_r, col_r, xrow_r, rr_r;
    logic       xfer_r, xdir_r, cas_seen_r;
    logic [1:0] seg_r;
    logic [4:0] cs_q = 5'h1f;
    int         refresh_cnt = 0;
    logic [255:0] sr [5];
    logic [7:0]   sptr;
    // ---------------
    // strobe captures
    // ---------------
    always @(negedge row_strobe_n)
    begin
        row_r = multiplexed_address;
        xfer_r = !transfer_select_output_enable_n;
        cas_seen_r = 1'b0;
        if (xfer_r)
        begin
            xrow_r = multiplexed_address;
            xdir_r = write_select_n;
        end
    end
    always @(posedge row_strobe_n)
        if (!cas_seen_r && !xfer_r)
        begin
            rr_r = row_r;
            refresh_cnt++;
        end
    always @(column_strobe_n)
    begin
        for (int i = 0; i < 5; i++)
            if (cs_q[i] && !column_strobe_n[i])
            begin
                col_r = multiplexed_address;
                cas_seen_r = 1'b1;
                if (xfer_r)
                    seg_r = multiplexed_address[7:6];
                else if (!write_select_n)
                    mem[{row_r, multiplexed_address}][i] = random_data_io_out[i];
            end
        cs_q = column_strobe_n;
    end
    // floating bits show the inverse, so a mistimed sample reads wrong
    always @*
        for (int i = 0; i < 5; i++)
            dev_q[i] = (!row_strobe_n && !xfer_r && write_select_n && !column_strobe_n[i]
                && !transfer_select_output_enable_n) ? mem[{row_r, col_r}][i] : ~mem[{row_r, col_r}][i];
    // a load into the registers restarts the stream at the chosen segment
    always @(posedge row_strobe_n)
        if (xfer_r && xdir_r)
        begin
            for (int i = 0; i < 5; i++)
                for (int j = 0; j < 256; j++)
                    sr[i][j] = mem[{xrow_r, 8'(j)}][i];
            sptr = {seg_r, 6'h00};
        end
    always @(posedge sclk)
        if (row_strobe_n || !xfer_r)
            sptr = sptr + 8'h01;
    always @*
        for (int i = 0; i < 5; i++)
            serial_data_output[i] = serial_output_enable_n ? ~sr[i][sptr] : sr[i][sptr];
endmodule : vram_dev_model
`default_nettype wire
